// ===== src/uclr_loader.sv
// Purpose: per-core update trigger, load engine and update signature register
// Assumes: firmware keeps the trigger sequence; memory on the core clock
// Notes:   hard reset is arst_n_in; soft init keeps the loaded update
`timescale 1ns/1ps

// Summary of operation
// - hard reset discards the loaded update
// - soft init keeps the loaded update
// - repeated identical loads act as one
// - each core has its own update facility
// - identify writes revision; none loaded, untouched
// - revision in 63:32, 31:0 reserved
// - signature equals loaded update revision
// - reading signature never disturbs the update
// - trigger sequence is for loader revision 1
// - reject update with mismatching processor signature
module uclr_loader #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    clk_en_in,
  // core events
  input  wire logic                    soft_init_in,
  input  wire logic                    identify_in,
  input  wire logic [31:0]             proc_sig_in,
  // model-specific register port
  input  wire uclr_pkg::uclr_reg_req_t reg_req_in,
  output logic [63:0]                  reg_rdata_out,
  output logic                         reg_rvalid_out,
  // update image memory
  input  wire uclr_pkg::uclr_mem_rsp_t mem_rsp_in,
  output logic                         mem_req_out,
  output logic [ADDR_W-1:0]            mem_addr_out,
  // status
  output logic                         busy_out,
  output logic                         update_active_out,
  output logic                         load_ok_out,
  output logic                         load_rej_out
);
  import uclr_pkg::*;

  if (ADDR_W != 32) begin : g_chk
    $error("uclr_loader: ADDR_W must be 32");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam uclr_top_st_t TOP_RST = '{st: UCLR_ST_IDLE, default: '0};

  uclr_top_st_t s_r;
  uclr_top_st_t s_nxt;
  logic         f_busy;
  logic         f_done;
  logic [31:0]  f_data;
  logic         trig_wr;
  logic         sig_wr;

  function automatic logic hit(input uclr_reg_req_t r, input logic [31:0] a);
    hit = (r.addr == a);
  endfunction : hit

  assign trig_wr = reg_req_in.wr && hit(reg_req_in, UCLR_ADDR_TRIGGER);
  assign sig_wr  = reg_req_in.wr && hit(reg_req_in, UCLR_ADDR_SIGNATURE);

  // ------------------------------------------------------------
  // header fetch
  // ------------------------------------------------------------
  uclr_fetch #(
    .ADDR_W (ADDR_W)
  ) u_fetch (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .clk_en_in    (clk_en_in),
    .start_in     (s_r.fetch_go),
    .addr_in      (s_r.fetch_addr),
    .mem_rsp_in   (mem_rsp_in),
    .mem_req_out  (mem_req_out),
    .mem_addr_out (mem_addr_out),
    .busy_out     (f_busy),
    .done_out     (f_done),
    .data_out     (f_data)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.fetch_go = 1'b0;
    s_nxt.load_ok  = 1'b0;
    s_nxt.load_rej = 1'b0;
    s_nxt.rvalid   = reg_req_in.rd;
    s_nxt.rdata    = '0;
    // reads only look; nothing of the active update changes here
    if (reg_req_in.rd && hit(reg_req_in, UCLR_ADDR_SIGNATURE)) begin
      s_nxt.rdata = {s_r.sig_hi, UCLR_RSVD_VALUE};
    end
    // trigger reads back zero: the value is a command only
    if (sig_wr) begin
      s_nxt.sig_hi = reg_req_in.wdata[63:UCLR_SIG_LSB];
    end
    // identify after a write in the same cycle: hardware update wins
    if (identify_in && s_r.loaded) begin
      s_nxt.sig_hi = s_r.active_rev;
    end
    case (s_r.st)
      UCLR_ST_IDLE: begin
        // payload alignment and mapping are firmware's duty; the
        // header sits 48 bytes below the given address
        if (trig_wr && !f_busy) begin
          s_nxt.hdr_base   = reg_req_in.wdata[31:0] - UCLR_HDR_BYTES;
          s_nxt.fetch_addr = reg_req_in.wdata[31:0] - UCLR_HDR_BYTES + UCLR_HDR_REV_OFS;
          s_nxt.fetch_go   = 1'b1;
          s_nxt.st         = UCLR_ST_REV;
        end
      end
      UCLR_ST_REV: begin
        if (f_done) begin
          s_nxt.new_rev    = f_data;
          s_nxt.fetch_addr = s_r.hdr_base + UCLR_HDR_SIG_OFS;
          s_nxt.fetch_go   = 1'b1;
          s_nxt.st         = UCLR_ST_SIG;
        end
      end
      UCLR_ST_SIG: begin
        if (f_done) begin
          s_nxt.sig_ok     = (f_data == proc_sig_in);
          s_nxt.fetch_addr = s_r.hdr_base + UCLR_HDR_LDR_OFS;
          s_nxt.fetch_go   = 1'b1;
          s_nxt.st         = UCLR_ST_LDR;
        end
      end
      UCLR_ST_LDR: begin
        if (f_done) begin
          s_nxt.st = UCLR_ST_IDLE;
          // other loader revisions need another sequence: refuse them
          if (s_r.sig_ok && f_data == UCLR_LOADER_REV) begin
            // plain overwrite, so loading the same image again is harmless
            s_nxt.loaded     = 1'b1;
            s_nxt.active_rev = s_r.new_rev;
            s_nxt.load_ok    = 1'b1;
          end else begin
            s_nxt.load_rej = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = UCLR_ST_IDLE;
      end
    endcase
    // soft init abandons a load in flight but keeps what is loaded
    if (soft_init_in) begin
      s_nxt.st         = UCLR_ST_IDLE;
      s_nxt.fetch_go   = 1'b0;
      // a load finishing in the same cycle is dropped with no result
      s_nxt.loaded     = s_r.loaded;
      s_nxt.active_rev = s_r.active_rev;
      s_nxt.load_ok    = 1'b0;
      s_nxt.load_rej   = 1'b0;
    end
    // busy kept as its own flop so the output has no decode behind it
    s_nxt.busy = (s_nxt.st != UCLR_ST_IDLE);
  end

  // ------------------------------------------------------------
  // registers: the hard reset is the only thing that drops the update
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= TOP_RST;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out     = s_r.rdata;
  assign reg_rvalid_out    = s_r.rvalid;
  assign busy_out          = s_r.busy;
  assign update_active_out = s_r.loaded;
  assign load_ok_out       = s_r.load_ok;
  assign load_rej_out      = s_r.load_rej;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_hard_clear;
    @(posedge clk_in) !arst_n_in |-> !update_active_out && s_r.active_rev == '0;
  endproperty
  a_hard_clear: assert property (p_hard_clear) else $error("update survived hard reset");

  property p_init_keep;
    @(posedge clk_in) disable iff (!arst_n_in)
      soft_init_in && clk_en_in && update_active_out |=>
        update_active_out && s_r.active_rev == $past(s_r.active_rev);
  endproperty
  a_init_keep: assert property (p_init_keep) else $error("soft init lost update");

  property p_ident_load;
    @(posedge clk_in) disable iff (!arst_n_in)
      identify_in && clk_en_in && s_r.loaded |=> s_r.sig_hi == $past(s_r.active_rev);
  endproperty
  a_ident_load: assert property (p_ident_load) else $error("identify missed revision");

  property p_ident_none;
    @(posedge clk_in) disable iff (!arst_n_in)
      identify_in && clk_en_in && !s_r.loaded && !sig_wr |=> $stable(s_r.sig_hi);
  endproperty
  a_ident_none: assert property (p_ident_none) else $error("signature changed, none loaded");

  property p_sig_read;
    @(posedge clk_in) disable iff (!arst_n_in)
      reg_req_in.rd && clk_en_in && hit(reg_req_in, UCLR_ADDR_SIGNATURE) |=>
        reg_rvalid_out && reg_rdata_out == {$past(s_r.sig_hi), UCLR_RSVD_VALUE};
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature read format wrong");

  property p_ok_rev;
    @(posedge clk_in) disable iff (!arst_n_in)
      load_ok_out |-> update_active_out && s_r.active_rev == s_r.new_rev;
  endproperty
  a_ok_rev: assert property (p_ok_rev) else $error("active revision not header revision");

  property p_rej_keep;
    @(posedge clk_in) disable iff (!arst_n_in)
      load_rej_out |-> s_r.active_rev == $past(s_r.active_rev) && !load_ok_out;
  endproperty
  a_rej_keep: assert property (p_rej_keep) else $error("rejected load changed state");

  property p_read_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      reg_req_in.rd && !reg_req_in.wr && clk_en_in && s_r.st == UCLR_ST_IDLE |=>
        $stable(s_r.active_rev) && $stable(s_r.loaded);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed update");

  property p_trig_cmd;
    @(posedge clk_in) disable iff (!arst_n_in)
      reg_req_in.rd && clk_en_in && hit(reg_req_in, UCLR_ADDR_TRIGGER) |=>
        reg_rvalid_out && reg_rdata_out == '0;
  endproperty
  a_trig_cmd: assert property (p_trig_cmd) else $error("trigger value readable");

  property p_trig_start;
    @(posedge clk_in) disable iff (!arst_n_in)
      trig_wr && clk_en_in && !f_busy && !soft_init_in && s_r.st == UCLR_ST_IDLE |=>
        s_r.st == UCLR_ST_REV ##1 (!clk_en_in || mem_req_out);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start load");

  property p_freeze;
    @(posedge clk_in) disable iff (!arst_n_in)
      !clk_en_in |=> $stable(s_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_fetch_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
      mem_req_out && !mem_rsp_in.ack && clk_en_in |=> mem_req_out && $stable(mem_addr_out);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("memory request dropped early");

  property p_init_abort;
    @(posedge clk_in) disable iff (!arst_n_in)
      soft_init_in && clk_en_in |=> !busy_out && !load_ok_out && !load_rej_out;
  endproperty
  a_init_abort: assert property (p_init_abort) else $error("soft init left a load running");

  property p_trig_addr;
    @(posedge clk_in) disable iff (!arst_n_in)
      trig_wr && clk_en_in && !f_busy && !soft_init_in && s_r.st == UCLR_ST_IDLE |=>
        s_r.fetch_addr == $past(reg_req_in.wdata[31:0]) - UCLR_HDR_BYTES + UCLR_HDR_REV_OFS;
  endproperty
  a_trig_addr: assert property (p_trig_addr) else $error("revision fetch address wrong");

  property p_sig_rsvd;
    @(posedge clk_in) disable iff (!arst_n_in)
      reg_rvalid_out |-> reg_rdata_out[UCLR_SIG_LSB-1:0] == UCLR_RSVD_VALUE;
  endproperty
  a_sig_rsvd: assert property (p_sig_rsvd) else $error("reserved bits not zero");

  property p_result_end;
    @(posedge clk_in) disable iff (!arst_n_in)
      load_ok_out || load_rej_out |-> !busy_out && !(load_ok_out && load_rej_out);
  endproperty
  a_result_end: assert property (p_result_end) else $error("load result while busy");

  property p_ldr_reject;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_r.st == UCLR_ST_LDR && f_done && f_data != UCLR_LOADER_REV && !soft_init_in &&
        clk_en_in |=> load_rej_out && !load_ok_out;
  endproperty
  a_ldr_reject: assert property (p_ldr_reject) else $error("foreign loader accepted");

  property p_rvalid_any;
    @(posedge clk_in) disable iff (!arst_n_in)
      reg_req_in.rd && clk_en_in |=> reg_rvalid_out;
  endproperty
  a_rvalid_any: assert property (p_rvalid_any) else $error("read got no answer");

  c_load_ok:  cover property (@(posedge clk_in) disable iff (!arst_n_in) load_ok_out);
  c_load_rej: cover property (@(posedge clk_in) disable iff (!arst_n_in) load_rej_out);
  c_ident:    cover property (@(posedge clk_in) disable iff (!arst_n_in)
                identify_in && s_r.loaded ##2 reg_req_in.rd);
  c_abort:    cover property (@(posedge clk_in) disable iff (!arst_n_in) soft_init_in && busy_out);
  c_freeze:   cover property (@(posedge clk_in) disable iff (!arst_n_in) !clk_en_in);

endmodule : uclr_loader

// ===== src/uclr_pkg.sv
// Purpose: shared constants and types for the update loader and signature block
// Assumes: one instance per core, model-specific register port on the core clock
// Notes:   header field offsets are relative to the image start (payload - 48)
package uclr_pkg;

  // ------------------------------------------------------------
  // register addresses and layout
  // ------------------------------------------------------------
  localparam logic [31:0] UCLR_ADDR_TRIGGER   = 32'h0000_0079;
  localparam logic [31:0] UCLR_ADDR_SIGNATURE = 32'h0000_008B;
  localparam int          UCLR_SIG_LSB        = 32;
  localparam logic [31:0] UCLR_SIG_RESET      = 32'h0000_0000;
  localparam logic [31:0] UCLR_RSVD_VALUE     = 32'h0000_0000;

  // ------------------------------------------------------------
  // update image layout
  // ------------------------------------------------------------
  localparam logic [31:0] UCLR_HDR_BYTES      = 32'h0000_0030;
  localparam logic [31:0] UCLR_HDR_REV_OFS    = 32'h0000_0004;
  localparam logic [31:0] UCLR_HDR_SIG_OFS    = 32'h0000_000C;
  localparam logic [31:0] UCLR_HDR_LDR_OFS    = 32'h0000_0014;
  localparam logic [31:0] UCLR_LOADER_REV     = 32'h0000_0001;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [63:0] wdata;
  } uclr_reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } uclr_mem_rsp_t;

  typedef enum logic [4:0] {
    UCLR_ST_IDLE = 5'h01,
    UCLR_ST_REV  = 5'h02,
    UCLR_ST_SIG  = 5'h04,
    UCLR_ST_LDR  = 5'h08,
    UCLR_ST_WAIT = 5'h10
  } uclr_state_t;

  typedef struct packed {
    logic        busy;
    logic        req;
    logic [31:0] addr;
    logic        done;
    logic [31:0] data;
  } uclr_fetch_st_t;

  typedef struct packed {
    uclr_state_t st;
    logic        busy;
    logic [31:0] hdr_base;
    logic [31:0] new_rev;
    logic        sig_ok;
    logic        loaded;
    logic [31:0] active_rev;
    logic [31:0] sig_hi;
    logic [63:0] rdata;
    logic        rvalid;
    logic        fetch_go;
    logic [31:0] fetch_addr;
    logic        load_ok;
    logic        load_rej;
  } uclr_top_st_t;

endpackage : uclr_pkg

// ===== src/uclr_fetch.sv
// Purpose: single dword read from update image memory
// Assumes: memory answers on the core clock with a one-cycle ack
// Notes:   starts are ignored while a read is outstanding
`timescale 1ns/1ps
module uclr_fetch #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              clk_en_in,
  // command
  input  wire logic              start_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // memory
  input  wire uclr_pkg::uclr_mem_rsp_t mem_rsp_in,
  output logic                   mem_req_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  // result
  output logic                   busy_out,
  output logic                   done_out,
  output logic [31:0]            data_out
);
  import uclr_pkg::*;

  if (ADDR_W != 32) begin : g_chk
    $error("uclr_fetch: ADDR_W must be 32");
  end

  uclr_fetch_st_t s_r;
  uclr_fetch_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      if (start_in) begin
        s_nxt.busy = 1'b1;
        s_nxt.req  = 1'b1;
        s_nxt.addr = addr_in;
      end
    end else if (mem_rsp_in.ack) begin
      s_nxt.busy = 1'b0;
      s_nxt.req  = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.data = mem_rsp_in.rdata;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '0;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign mem_req_out  = s_r.req;
  assign mem_addr_out = s_r.addr;
  assign busy_out     = s_r.busy;
  assign done_out     = s_r.done;
  assign data_out     = s_r.data;

endmodule : uclr_fetch

// ===== verif/uclr_mem_model.sv
// Purpose: update image memory answering the loader's dword reads
// Assumes: image start given by base_in, fields as {rev, sig, ldr}
// Notes:   idle data toggles so a stale word never looks valid
`timescale 1ns/1ps
module uclr_mem_model
  import uclr_pkg::*;
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  // read request
  input  wire logic               req_in,
  input  wire logic [31:0]        addr_in,
  // image contents and pacing
  input  wire logic [31:0]        base_in,
  input  wire logic [95:0]        words_in,
  input  wire logic               slow_in,
  // answer
  output uclr_pkg::uclr_mem_rsp_t rsp_out
);
  logic [1:0]  wait_r;
  logic [31:0] word;

  // every address answers: all payload pages present and mapped
  always_comb begin
    case (addr_in - base_in)
      UCLR_HDR_REV_OFS: word = words_in[95:64];
      UCLR_HDR_SIG_OFS: word = words_in[63:32];
      UCLR_HDR_LDR_OFS: word = words_in[31:0];
      default:          word = ~rsp_out.rdata;
    endcase
  end

  // slow mode answers two cycles later than prompt mode
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_r  <= 2'h0;
      rsp_out <= '0;
    end else if (req_in && !rsp_out.ack && wait_r == {slow_in, 1'b0}) begin
      wait_r  <= 2'h0;
      rsp_out <= '{ack: 1'b1, rdata: word};
    end else begin
      wait_r  <= (req_in && !rsp_out.ack) ? wait_r + 2'h1 : 2'h0;
      rsp_out <= '{ack: 1'b0, rdata: ~rsp_out.rdata};
    end
  end
endmodule : uclr_mem_model

// ===== verif/uclr_loader_bench.sv
// Purpose: self-checking bench for the update loader and signature block
// Assumes: one core, image memory from uclr_mem_model
// Notes:   results are queued as notes and checked by a monitor
`timescale 1ns/1ps
module uclr_loader_bench;
  import uclr_pkg::*;
  // ------
  // signals
  // ------
  logic          clk_in       = 1'b0;
  logic          arst_n_in    = 1'b1;
  logic          clk_en       = 1'b1;
  logic          soft_init_in = 1'b0;
  logic          identify_in  = 1'b0;
  logic [31:0]   proc_sig_in  = 32'h0;
  uclr_reg_req_t reg_req_in   = '0;
  logic [31:0]   img_base     = 32'h100;
  logic [95:0]   img_words    = '0;
  logic          slow         = 1'b0;
  uclr_mem_rsp_t mem_rsp;
  logic [31:0]   mem_addr;
  logic [63:0]   rdata;
  logic          rvalid, mem_req, busy, active, ok, rej;
  logic [65:0]   notes[$];
  logic [65:0]   exp_note;
  logic [31:0]   rev_a;
  int            miscompares = 0;
  int            comparisons = 0;
  int            cycles      = 0;
  integer        seed        = 32'h47ebe19b;

  always #12.5 clk_in = ~clk_in;

  uclr_loader u_uclr_loader (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
    .soft_init_in(soft_init_in), .identify_in(identify_in), .proc_sig_in(proc_sig_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .mem_rsp_in(mem_rsp), .mem_req_out(mem_req), .mem_addr_out(mem_addr),
    .busy_out(busy), .update_active_out(active), .load_ok_out(ok), .load_rej_out(rej));

  uclr_mem_model u_uclr_mem_model (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .req_in(mem_req), .addr_in(mem_addr), .base_in(img_base), .words_in(img_words),
    .slow_in(slow), .rsp_out(mem_rsp));

  // ------
  // tasks
  // ------
  task automatic chk(input string name, input logic [65:0] exp, input logic [65:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // a clear edge between requests so no pulse is assigned twice at once
  task automatic reg_op(input logic wr, input logic [31:0] addr, input logic [63:0] d);
    reg_req_in = '{wr: wr, rd: ~wr, addr: addr, wdata: d};
    tick(1);
    reg_req_in = '0;
    tick(1);
  endtask : reg_op

  task automatic rd(input logic [31:0] addr, input logic [63:0] exp);
    notes.push_back({2'b00, exp});
    reg_op(1'b0, addr, 64'h0);
  endtask : rd

  task automatic identify();
    identify_in = 1'b1;
    tick(1);
    identify_in = 1'b0;
    tick(1);
  endtask : identify

  task automatic sig_check(input logic [31:0] rev);
    reg_op(1'b1, UCLR_ADDR_SIGNATURE, 64'h0);
    identify();
    rd(UCLR_ADDR_SIGNATURE, {rev, 32'h0});
  endtask : sig_check

  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
    chk("busy", 66'h0, {65'h0, busy});
  endtask : wait_idle

  task automatic trigger(input logic [31:0] rev, input logic [31:0] sig,
                         input logic [31:0] ldr);
    img_words = {rev, sig, ldr};
    img_base  = ({$random(seed)} % 32'h0FF0) << 4;
    reg_op(1'b1, UCLR_ADDR_TRIGGER, {32'h0, img_base + 32'h30});
    chk("busy", 66'h1, {65'h0, busy});
  endtask : trigger

  task automatic load(input logic [31:0] rev, input logic [31:0] sig,
                      input logic [31:0] ldr, input logic good);
    notes.push_back({~good, good, 64'h0});
    trigger(rev, sig, ldr);
    wait_idle();
  endtask : load

  // ------
  // monitor and timeout
  // ------
  // pulses stand one cycle: the falling edge sees each exactly once
  always @(negedge clk_in) begin
    if (rvalid || ok || rej) begin
      exp_note = (notes.size() > 0) ? notes.pop_front() : {2'b11, 64'h0};
      chk("result", exp_note, {rej, ok, rvalid ? rdata : 64'h0});
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ------
  // scenarios
  // ------
  initial begin
    #1;
    arst_n_in   = 1'b0;
    tick(10);
    arst_n_in   = 1'b1;
    tick(1);
    proc_sig_in = $random(seed);
    rev_a       = $random(seed) | 32'h1;
    chk("active", 66'h0, {65'h0, active});
    rd(UCLR_ADDR_SIGNATURE, 64'h0);
    rd(UCLR_ADDR_TRIGGER, 64'h0);
    rd(32'h0000_0077, 64'h0);
    reg_op(1'b1, UCLR_ADDR_SIGNATURE, {32'hA5A5_5A5A, 32'hFFFF_FFFF});
    identify();
    rd(UCLR_ADDR_SIGNATURE, {32'hA5A5_5A5A, 32'h0});
    sig_check(32'h0);
    load(rev_a, proc_sig_in, UCLR_LOADER_REV, 1'b1);
    chk("active", 66'h1, {65'h0, active});
    sig_check(rev_a);
    rd(UCLR_ADDR_SIGNATURE, {rev_a, 32'h0});
    slow = 1'b1;
    load(rev_a, proc_sig_in, UCLR_LOADER_REV, 1'b1);
    sig_check(rev_a);
    load(rev_a + 32'h1, ~proc_sig_in, UCLR_LOADER_REV, 1'b0);
    load(rev_a + 32'h1, proc_sig_in, 32'h2, 1'b0);
    sig_check(rev_a);
    // clock enable low: a signature write must not land
    clk_en = 1'b0;
    reg_op(1'b1, UCLR_ADDR_SIGNATURE, 64'h0);
    clk_en = 1'b1;
    rd(UCLR_ADDR_SIGNATURE, {rev_a, 32'h0});
    // soft init alone, then in the middle of a load
    soft_init_in = 1'b1;
    tick(1);
    soft_init_in = 1'b0;
    tick(1);
    chk("active", 66'h1, {65'h0, active});
    trigger(rev_a + 32'h2, proc_sig_in, UCLR_LOADER_REV);
    soft_init_in = 1'b1;
    tick(1);
    soft_init_in = 1'b0;
    wait_idle();
    sig_check(rev_a);
    // hard reset in mid-run
    arst_n_in = 1'b0;
    tick(2);
    arst_n_in = 1'b1;
    tick(1);
    chk("active", 66'h0, {65'h0, active});
    identify();
    rd(UCLR_ADDR_SIGNATURE, 64'h0);
    tick(3);
    chk("notes left", 66'h0, 66'(notes.size()));
    print_verdict();
  end
endmodule : uclr_loader_bench
